// [rtl/beam_pen_pkg.sv]
// Operation
// RL1: blink gate overrides line pattern when selected
// RL2: mode word bits 3,4 set/clear flash_enable
// RL3: beam on = flash phase AND line, if flashing
// RL4: flash phase 266 ms set, 266 ms clear
// RL5: four-stage divider of 60 Hz tick clocks phase
// RL6: brightness loads bits 7-9 when bit 10 set
// RL7: brightness selects one of seven levels; the code has a 3-bit level, eight values 0-7
// RL8: pen hit without status enable forces brightness high
// RL9: mode-enabled pen hit raises pen interrupt flag
// RL10: one pen flag per element, lockout until done
// RL11: pending hit only when enabled, not edge column
// RL12: flag at vector step trailing edge or done
// RL13: point done pulse 100 ns forms operation done
// RL14: flag sets lockout and post flag
// RL15: flag raises interrupt request to host
// RL16: post flag loads converters, stops vector steps
// RL17: resume continues vector, start reloads program counter
// RL18: pen interrupt drives vector 324 octal on bus
// RL19: slave sync with interrupt state clears flags
// RL20: line type selects solid, long, short, dot-dash
// RL21: line counter preset fifteen, decremented by half-clock
// RL22: initialization clears all pen interrupt state
package beam_pen_pkg;
	localparam int unsigned clk_hz = 10_000_000;
	localparam int unsigned point_done_ns = 100;
	localparam int unsigned point_done_cycles =
		(point_done_ns * (clk_hz / 1_000_000) + 999) / 1000 < 1 ? 1 :
		(point_done_ns * (clk_hz / 1_000_000) + 999) / 1000;
	localparam int unsigned flash_half_ms = 266;
	localparam int unsigned div_stages = 4;
	localparam logic [3:0] line_preset = 4'hf;
	localparam logic [15:0] pen_vector = 16'h00d4;
	localparam logic [15:0] stop_vector_dflt = 16'h0140;
	localparam int unsigned blink_a_bit = 3;
	localparam int unsigned blink_b_bit = 4;
	localparam int unsigned bright_lo_bit = 7;
	localparam int unsigned bright_en_bit = 10;
	localparam logic [31:0] reg_ctrl = 32'h0000_0000;
	localparam logic [31:0] reg_status = 32'h0000_0004;
	localparam logic [31:0] reg_vector = 32'h0000_0008;
	localparam logic [31:0] reg_cmd = 32'h0000_000c;
	localparam logic [2:0] bright_rst = 3'h0;
	typedef enum logic [1:0] {
		line_solid = 2'b00,
		line_long = 2'b01,
		line_short = 2'b10,
		line_dotdash = 2'b11
	} line_type_t;
	typedef enum logic [2:0] {
		elem_vector = 3'b000,
		elem_point = 3'b001,
		elem_relpoint = 3'b010,
		elem_char = 3'b011,
		elem_other = 3'b100
	} elem_kind_t;
	typedef struct packed {
		logic [2:0] brightness_level;
		logic beam_on_level;
		logic interrupt_request;
		logic pen_hit_post;
		logic step_hold;
	} display_out_t;
endpackage : beam_pen_pkg

// [rtl/beam_pen_irq.sv]
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module beam_pen_irq #(
	parameter int unsigned flash_half_ms = 266
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mode_load_pulse,
	input wire logic [10:0] mode_word,
	input wire logic [2:0] elem_kind,
	input wire logic vector_start,
	input wire logic down_count_clk,
	input wire logic vector_intensify,
	input wire logic mains_tick,
	input wire logic pen_pulse_n,
	input wire logic char_edge_column,
	input wire logic pen_irq_enable_status_a,
	input wire logic vector_step_clock,
	input wire logic post_point_intensity,
	input wire logic char_done,
	input wire logic start_cmd_n,
	input wire logic slave_sync,
	input wire logic interrupt_grant,
	output logic [15:0] bus_vector,
	output logic bus_vector_oe,
	output logic load_converters,
	output logic operation_done_n,
	output beam_pen_pkg::display_out_t disp
);
	// async pins pass two flops
	logic [1:0] pen_s_ff, tick_s_ff, step_s_ff, ssync_s_ff, grant_s_ff;
	logic pen_d_ff, tick_d_ff, step_d_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pen_s_ff <= 2'b11;
			tick_s_ff <= 2'b00;
			step_s_ff <= 2'b00;
			ssync_s_ff <= 2'b00;
			grant_s_ff <= 2'b00;
			pen_d_ff <= 1'b1;
			tick_d_ff <= 1'b0;
			step_d_ff <= 1'b0;
		end else begin
			pen_s_ff <= {pen_s_ff[0], pen_pulse_n};
			tick_s_ff <= {tick_s_ff[0], mains_tick};
			step_s_ff <= {step_s_ff[0], vector_step_clock};
			ssync_s_ff <= {ssync_s_ff[0], slave_sync};
			grant_s_ff <= {grant_s_ff[0], interrupt_grant};
			pen_d_ff <= pen_s_ff[1];
			tick_d_ff <= tick_s_ff[1];
			step_d_ff <= step_s_ff[1];
		end
	end
	wire pen_edge = pen_d_ff & ~pen_s_ff[1];
	wire tick_edge = tick_s_ff[1] & ~tick_d_ff;
	wire step_fall = step_d_ff & ~step_s_ff[1];

	// mode word fields
	logic flash_enable_ff, pen_irq_enable_gm_ff;
	logic [1:0] line_type_ff;
	logic [2:0] brightness_ff;
	logic [3:0] div_ff;
	logic flash_phase_ff;
	logic [3:0] line_cnt_ff;
	logic half_ff;
	wire blink_set = mode_word[beam_pen_pkg::blink_a_bit];
	wire blink_clr = mode_word[beam_pen_pkg::blink_b_bit];
	wire bright_en = mode_word[beam_pen_pkg::bright_en_bit];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_enable_ff <= 1'b0;
			pen_irq_enable_gm_ff <= 1'b0;
			line_type_ff <= 2'b00;
			brightness_ff <= beam_pen_pkg::bright_rst;
		end else if (mode_load_pulse) begin
			if (blink_set)
				flash_enable_ff <= 1'b1; // RL2
			else if (blink_clr)
				flash_enable_ff <= 1'b0; // RL2
			if (mode_word[5])
				pen_irq_enable_gm_ff <= mode_word[6];
			if (mode_word[2])
				line_type_ff <= mode_word[1:0];
			if (bright_en)
				brightness_ff <= mode_word[9:beam_pen_pkg::bright_lo_bit]; // RL6
		end
	end

	// mains tick divider; only top stage drives the phase
	wire div_carry = tick_edge & (div_ff == 4'hf);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 4'h0;
			flash_phase_ff <= 1'b0;
		end else begin
			if (tick_edge)
				div_ff <= div_ff + 4'h1; // RL5
			// 3.75 Hz rising edge per 16 ticks toggles: ~266 ms each half
			if (div_carry)
				flash_phase_ff <= ~flash_phase_ff; // RL4
		end
	end

	// line counter, preset at vector start, half-rate down clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_cnt_ff <= beam_pen_pkg::line_preset;
			half_ff <= 1'b0;
		end else if (vector_start) begin
			line_cnt_ff <= beam_pen_pkg::line_preset; // RL21
			half_ff <= 1'b0;
		end else if (down_count_clk) begin
			half_ff <= ~half_ff;
			if (half_ff)
				line_cnt_ff <= line_cnt_ff - 4'h1; // RL21
		end
	end
	logic line_out;
	always_comb begin
		unique case (line_type_ff) // RL20
		2'b00: line_out = 1'b1;
		2'b01: line_out = line_cnt_ff[3];
		2'b10: line_out = line_cnt_ff[2];
		2'b11: line_out = (line_cnt_ff[1] & line_cnt_ff[0] & ~line_cnt_ff[2]) | ~line_cnt_ff[3];
		endcase
	end
	wire pattern = vector_intensify & line_out;
	// blink gate wins over the pattern while enabled
	wire beam_on = flash_enable_ff ? (flash_phase_ff & pattern) : pattern; // RL1 RL3

	// point done pulse
	localparam int unsigned pd_w = $clog2(beam_pen_pkg::point_done_cycles + 1);
	logic [pd_w-1:0] pd_cnt_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pd_cnt_ff <= '0;
		else if (post_point_intensity)
			pd_cnt_ff <= pd_w'(beam_pen_pkg::point_done_cycles); // RL13
		else if (pd_cnt_ff != '0)
			pd_cnt_ff <= pd_cnt_ff - pd_w'(1);
	end
	wire point_done = (pd_cnt_ff != '0);
	wire op_done = point_done | char_done; // RL13

	// pen logic
	logic pen_hit_pending_ff, pen_hit_flag_ff, pen_hit_post_ff, lockout_ff, irq_ff;
	logic vector_oe_ff, ackdone_ff;
	wire is_vec = (elem_kind == beam_pen_pkg::elem_vector);
	wire is_pt = (elem_kind == beam_pen_pkg::elem_point) |
		(elem_kind == beam_pen_pkg::elem_relpoint) |
		(elem_kind == beam_pen_pkg::elem_char);
	wire pen_arm = pen_irq_enable_gm_ff & ~char_edge_column & ~lockout_ff; // RL11 RL10
	wire flag_set = pen_hit_pending_ff & ((is_vec & step_fall) | (is_pt & op_done)); // RL12
	wire ack = ssync_s_ff[1] & irq_ff & vector_oe_ff; // RL19
	wire clear_flags_n = ~ack;
	logic cmd_resume_ff;
	logic [31:0] stop_vec_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pen_hit_pending_ff <= 1'b0; // RL22
			pen_hit_flag_ff <= 1'b0;
			pen_hit_post_ff <= 1'b0;
			lockout_ff <= 1'b0;
			irq_ff <= 1'b0;
			vector_oe_ff <= 1'b0;
			ackdone_ff <= 1'b0;
		end else if (!start_cmd_n) begin
			pen_hit_pending_ff <= 1'b0; // RL17 RL22
			pen_hit_flag_ff <= 1'b0;
			pen_hit_post_ff <= 1'b0;
			lockout_ff <= 1'b0;
			irq_ff <= 1'b0;
			vector_oe_ff <= 1'b0;
			ackdone_ff <= 1'b0;
		end else begin
			ackdone_ff <= ack;
			if (pen_edge & vector_intensify & pen_arm)
				pen_hit_pending_ff <= 1'b1; // RL9 RL11
			else if (flag_set)
				pen_hit_pending_ff <= 1'b0;
			if (flag_set) begin
				pen_hit_flag_ff <= 1'b1; // RL10
				lockout_ff <= 1'b1; // RL14
				pen_hit_post_ff <= 1'b1; // RL14
				irq_ff <= 1'b1; // RL15
			end else if (!clear_flags_n) begin
				pen_hit_flag_ff <= 1'b0; // RL19
				lockout_ff <= 1'b0;
				irq_ff <= 1'b0;
			end
			// a new hit outranks a resume landing in the same cycle
			if (cmd_resume_ff & ~flag_set)
				pen_hit_post_ff <= 1'b0; // RL17
			if (irq_ff & grant_s_ff[1] & ~ack)
				vector_oe_ff <= 1'b1; // RL18
			else if (ack | ~irq_ff)
				vector_oe_ff <= 1'b0;
		end
	end

	// apb slave: zero wait, unmapped reads zero with error
	wire acc = psel & penable;
	wire hit_ctrl = (paddr == beam_pen_pkg::reg_ctrl);
	wire hit_stat = (paddr == beam_pen_pkg::reg_status);
	wire hit_vec = (paddr == beam_pen_pkg::reg_vector);
	wire hit_cmd = (paddr == beam_pen_pkg::reg_cmd);
	wire mapped = hit_ctrl | hit_stat | hit_vec | hit_cmd;
	wire [31:0] stat_word = {17'h0, ackdone_ff, irq_ff, pen_hit_post_ff, lockout_ff,
		pen_hit_flag_ff, pen_hit_pending_ff, flash_phase_ff, flash_enable_ff,
		pen_irq_enable_gm_ff, line_type_ff, brightness_ff, line_cnt_ff[3]};
	wire [31:0] rd_mux = hit_ctrl ? {29'h0, brightness_ff} :
		hit_stat ? stat_word :
		hit_vec ? stop_vec_ff : 32'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			stop_vec_ff <= {16'h0, beam_pen_pkg::stop_vector_dflt};
			cmd_resume_ff <= 1'b0;
		end else begin
			cmd_resume_ff <= acc & pwrite & hit_cmd & pwdata[0]; // RL17
			if (psel & ~penable & ~pwrite)
				prdata <= rd_mux;
			if (acc & pwrite & hit_vec)
				stop_vec_ff <= {16'h0, pwdata[15:0]};
		end
	end
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	// outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp <= '0;
			bus_vector <= 16'h0;
		end else begin
			// pen hit lights all three grid lines unless status enable set
			disp.brightness_level <= (pen_edge & ~pen_irq_enable_status_a) ?
				3'h7 : brightness_ff; // RL7 RL8
			disp.beam_on_level <= beam_on; // RL3
			disp.interrupt_request <= irq_ff; // RL15
			disp.pen_hit_post <= pen_hit_post_ff;
			disp.step_hold <= pen_hit_post_ff & is_vec; // RL16
			bus_vector <= irq_ff ? beam_pen_pkg::pen_vector : stop_vec_ff[15:0]; // RL18
		end
	end
	assign bus_vector_oe = vector_oe_ff;
	assign load_converters = pen_hit_post_ff; // RL16
	assign operation_done_n = ~op_done; // RL13
endmodule : beam_pen_irq

// [sim/beam_pen_irq_monitor.sv]
`timescale 1ns/10ps
module beam_pen_irq_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mode_load_pulse,
	input wire logic pen_pulse_n,
	input wire logic pen_irq_enable_status_a,
	input wire logic start_cmd_n,
	input wire logic slave_sync,
	input wire logic [15:0] bus_vector,
	input wire logic bus_vector_oe,
	input wire logic load_converters,
	input wire logic operation_done_n,
	input wire logic pslverr,
	input wire beam_pen_pkg::display_out_t disp
);
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pen_vector_out: assert property (disp.interrupt_request && bus_vector_oe |->
		bus_vector == beam_pen_pkg::pen_vector) else $error("pen vector wrong");
	a_post_loads_conv: assert property ($rose(load_converters) |-> ##[0:1]
		disp.pen_hit_post) else $error("converter load without post");
	a_irq_sets_post: assert property ($rose(disp.interrupt_request) |-> ##[0:1]
		load_converters) else $error("irq without post");
	a_done_one_cycle: assert property ($fell(operation_done_n) |=> operation_done_n)
		else $error("done pulse too long");
	a_bright_only_load: assert property ($changed(disp.brightness_level) &&
		pen_irq_enable_status_a && $past(pen_irq_enable_status_a, 4) |->
		$past(mode_load_pulse) || $past(mode_load_pulse, 2)) else $error("brightness moved");
	a_pen_forces_max: assert property ($fell(pen_pulse_n) && !pen_irq_enable_status_a |->
		##[2:6] disp.brightness_level == 3'h7) else $error("no brightness override");
	a_ack_clears_irq: assert property (disp.interrupt_request && slave_sync &&
		bus_vector_oe |-> ##[1:4] !disp.interrupt_request) else $error("ack ignored");
	a_start_clears: assert property (!start_cmd_n |-> ##[1:2]
		!disp.interrupt_request && !disp.pen_hit_post) else $error("start kept pen state");
	c_irq: cover property ($rose(disp.interrupt_request));
	c_hold: cover property ($rose(disp.step_hold));
	c_err: cover property (pslverr);
endmodule : beam_pen_irq_monitor
bind beam_pen_irq beam_pen_irq_monitor u_monitor (.pclk(pclk), .presetn(presetn),
	.mode_load_pulse(mode_load_pulse), .pen_pulse_n(pen_pulse_n),
	.pen_irq_enable_status_a(pen_irq_enable_status_a), .start_cmd_n(start_cmd_n),
	.slave_sync(slave_sync), .bus_vector(bus_vector), .bus_vector_oe(bus_vector_oe),
	.load_converters(load_converters), .operation_done_n(operation_done_n),
	.pslverr(pslverr), .disp(disp));

// [sim/host_irq_model.sv]
`timescale 1ns/10ps
module host_irq_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic interrupt_request,
	input wire logic bus_vector_oe,
	input wire logic [15:0] bus_vector,
	input wire logic [3:0] lag,
	output logic interrupt_grant,
	output logic slave_sync,
	output logic [15:0] vector_seen
);
	logic [3:0] wait_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_ff <= 4'h0;
			interrupt_grant <= 1'h0;
			slave_sync <= 1'h0;
			vector_seen <= 16'h0;
		end else if (!interrupt_request) begin
			// sync held until the request drops
			wait_ff <= 4'h0;
			interrupt_grant <= 1'h0;
			slave_sync <= 1'h0;
		end else if (interrupt_grant && bus_vector_oe) begin
			vector_seen <= bus_vector;
			slave_sync <= 1'h1;
		end else if (wait_ff == lag) begin
			interrupt_grant <= 1'h1;
		end else begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule : host_irq_model

// [sim/beam_pen_irq_test.sv]
`timescale 1ns/10ps
module beam_pen_irq_test;
	typedef struct {logic w; logic [31:0] a, d, exp; logic err;} row_t;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic mode_load_pulse = 1'h0, vector_start = 1'h0, down_count_clk = 1'h0, mains_tick = 1'h0;
	logic vector_intensify = 1'h1, pen_pulse_n = 1'h1, char_edge_column = 1'h0, char_done = 1'h0;
	logic pen_irq_enable_status_a = 1'h1, vector_step_clock = 1'h1, post_point_intensity = 1'h0;
	logic start_cmd_n = 1'h1, slave_sync, interrupt_grant, bus_vector_oe, load_converters;
	logic operation_done_n, pready, pslverr, err;
	logic bright_max = 1'h0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic [10:0] mode_word = 11'h0;
	logic [2:0] elem_kind = 3'h0;
	logic [3:0] lag = 4'hf;
	logic [15:0] bus_vector, vector_seen;
	beam_pen_pkg::display_out_t disp;
	int err_total = 0, num_checks = 0, irq_rises = 0;
	row_t rows[5] = '{'{1'h0, 32'h8, 32'h0, 32'h140, 1'h0}, '{1'h1, 32'h8, 32'h1c4, 32'h0, 1'h0},
		'{1'h0, 32'h8, 32'h0, 32'h1c4, 1'h0}, '{1'h0, 32'h20, 32'h0, 32'h0, 1'h1},
		'{1'h1, 32'h24, 32'h5, 32'h0, 1'h1}};
	always #50 pclk = ~pclk;
	always @(posedge pclk) if (presetn && $rose(disp.interrupt_request)) irq_rises++;
	always @(posedge pclk) if (disp.brightness_level == 3'h7) bright_max <= 1'h1;
	beam_pen_irq u_beam_pen_irq (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .mode_load_pulse, .mode_word, .elem_kind, .vector_start,
		.down_count_clk, .vector_intensify, .mains_tick, .pen_pulse_n, .char_edge_column,
		.pen_irq_enable_status_a, .vector_step_clock, .post_point_intensity, .char_done,
		.start_cmd_n, .slave_sync, .interrupt_grant, .bus_vector, .bus_vector_oe,
		.load_converters, .operation_done_n, .disp);
	host_irq_model u_host_irq_model (.pclk, .presetn, .interrupt_request(disp.interrupt_request),
		.bus_vector_oe, .bus_vector, .lag, .interrupt_grant, .slave_sync, .vector_seen);
	task end_of_test;
		if (err_total == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test
	task chk(input string what, input logic [31:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	task apb(input logic w, input logic [31:0] a, d);
		int i;
		i = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1 && i < 20) begin
			i++;
			@(posedge pclk);
		end
		if (i == 20) begin
			err_total++;
			end_of_test;
		end
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb
	task wait_irq(input logic lvl);
		int i;
		for (i = 0; disp.interrupt_request !== lvl && i < 60; i++) @(posedge pclk);
		if (i == 60) begin
			err_total++;
			end_of_test;
		end
	endtask : wait_irq
	task mode(input logic [10:0] w);
		@(posedge pclk);
		{mode_word, mode_load_pulse} <= {w, 1'h1};
		@(posedge pclk);
		mode_load_pulse <= 1'h0;
		tick(2);
	endtask : mode
	task pen_hit;
		@(posedge pclk);
		pen_pulse_n <= 1'h0;
		tick(2);
		pen_pulse_n <= 1'h1;
		tick(4);
	endtask : pen_hit
	// 0 post point, 1 char done, 2 start (low), 3 vector start, 4 down count
	task pulse(input int sel);
		@(posedge pclk);
		if (sel == 0) post_point_intensity <= 1'h1;
		if (sel == 1) char_done <= 1'h1;
		if (sel == 2) start_cmd_n <= 1'h0;
		if (sel == 3) vector_start <= 1'h1;
		if (sel == 4) down_count_clk <= 1'h1;
		@(posedge pclk);
		{post_point_intensity, char_done, vector_start, down_count_clk} <= 4'h0;
		start_cmd_n <= 1'h1;
		tick(3);
	endtask : pulse
	task ticks(input int n);
		repeat (n) begin
			mains_tick <= 1'h1;
			tick(4);
			mains_tick <= 1'h0;
			tick(4);
		end
	endtask : ticks
	initial begin
		tick(10);
		chk("irq in reset", 1'h0, disp.interrupt_request);
		chk("post in reset", 1'h0, disp.pen_hit_post);
		chk("done idle", 1'h1, operation_done_n);
		presetn <= 1'h1;
		foreach (rows[k]) begin
			apb(rows[k].w, rows[k].a, rows[k].d);
			if (!rows[k].w) chk("prdata", rows[k].exp, rd);
			chk("pslverr", rows[k].err, err);
		end
		chk("stop vector", 16'h01c4, bus_vector);
		mode(11'h580);
		chk("brightness", 3'h3, disp.brightness_level);
		mode(11'h280);
		chk("brightness kept", 3'h3, disp.brightness_level);
		mode(11'h008);
		ticks(15);
		chk("beam blanked", 1'h0, disp.beam_on_level);
		ticks(1);
		chk("beam shown", 1'h1, disp.beam_on_level);
		ticks(16);
		chk("beam blanked again", 1'h0, disp.beam_on_level);
		mode(11'h010);
		chk("solid beam", 1'h1, disp.beam_on_level);
		mode(11'h005);
		pulse(3);
		repeat (15) pulse(4);
		chk("long dash on", 1'h1, disp.beam_on_level);
		pulse(4);
		chk("long dash off", 1'h0, disp.beam_on_level);
		mode(11'h004);
		mode(11'h060);
		elem_kind <= 3'h1;
		pen_hit;
		chk("irq before done", 1'h0, disp.interrupt_request);
		pulse(0);
		wait_irq(1'h1);
		chk("converters", 1'h1, load_converters);
		pen_hit;
		pulse(0);
		wait_irq(1'h0);
		chk("vector read", beam_pen_pkg::pen_vector, vector_seen);
		chk("one flag", 1, irq_rises);
		apb(1'h1, beam_pen_pkg::reg_cmd, 32'h1);
		tick(2);
		chk("resume", 1'h0, load_converters);
		elem_kind <= 3'h0;
		pen_hit;
		vector_step_clock <= 1'h0;
		wait_irq(1'h1);
		chk("vector halted", 1'h1, disp.step_hold);
		pulse(2);
		chk("start clears", 1'h0, disp.step_hold);
		vector_step_clock <= 1'h1;
		char_edge_column <= 1'h1;
		elem_kind <= 3'h3;
		pen_hit;
		pulse(1);
		tick(10);
		chk("edge column", 1'h0, disp.interrupt_request);
		chk("no override", 1'h0, bright_max);
		char_edge_column <= 1'h0;
		pen_irq_enable_status_a <= 1'h0;
		pen_hit;
		chk("pen override", 1'h1, bright_max);
		end_of_test;
	end
	initial begin
		tick(20000);
		err_total++;
		end_of_test;
	end
endmodule : beam_pen_irq_test
